// >>> burst_power_pkg.sv
// Constants and types shared by the core clock burst power controller
// Operation
// - After reset controller is disabled and core clock runs continuously.
// - Burst period lasts exactly 31 slow reference clock periods.
// - Five-bit width sets on-time in 1/31 steps, duty n/31.
// - Width field resets to all ones, full duty.
// - Enabled: width 1F keeps clock on, width zero keeps it off.
// - On slot expiry request bus, stop clock after grant, grant DMA.
// - Wakeup interrupt while stopped restarts core clock immediately.
// - DMA access in progress finishes before core resumes work.
// - Any wakeup interrupt clears enable bit in hardware.
// - Clearing enable never changes the width field.
// - Enable zero: clock runs; enable one: gated by width compare.
// - Power-save enable bit resets to zero.
// - Stop bit stops clock after bus cycle past next slow edge.
// - After stop, clock restarts at next burst period or interrupt.
// - Gating never touches the DMA controller or system master clock.
// - Once stopped in doze, next burst period, interrupt, enable clear or reset restarts it.
// - Sleep wakeup must have system clock back within 2 msec.
// - Slow reference clock comes from always-running low frequency osc.
package burst_power_pkg;

  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned BURST_LEN        = 31;
  localparam logic [4:0]  BURST_LAST       = 5'h1e;
  localparam logic [4:0]  WIDTH_FULL       = 5'h1f;
  localparam logic [4:0]  WIDTH_RESET      = 5'h1f;
  localparam logic [3:0]  CTRL_OFFSET      = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET    = 4'h1;
  localparam int unsigned ENABLE_BIT       = 7;
  localparam int unsigned STOP_BIT         = 6;
  localparam int unsigned WAKE_LIMIT_US    = 2000;
  localparam int unsigned WAKE_LIMIT_CYC   =
    (WAKE_LIMIT_US * (CLK_HZ / 1_000_000));

  typedef enum logic [2:0] {
    st_run,
    st_bus_req,
    st_gated,
    st_dma_wait
  } gate_state_e;

  typedef struct packed {
    logic       enable;
    logic       stop;
    logic [4:0] width;
  } ctrl_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

endpackage

// >>> slow_edge_detect.sv
// Rising-edge pulse generator for the slow reference clock level
`timescale 1ns/1ps
module slow_edge_detect (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic slow_reference_clock,
  output logic      rise
);
  typedef struct packed {
    logic prev;
    logic rise;
  } edge_s;

  edge_s st_reg;
  edge_s st_next;

  // Input is taken as synchronous to mclk, so no extra synchroniser
  always_comb begin
    st_next = st_reg;
    st_next.prev = slow_reference_clock;
    st_next.rise = slow_reference_clock & ~st_reg.prev;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rise = st_reg.rise;
endmodule

// >>> burst_counter.sv
// Burst period counter stepping once per slow reference period
`timescale 1ns/1ps
module burst_counter (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       step,
  output logic [4:0]      count,
  output logic            period_start
);
  import burst_power_pkg::*;

  typedef struct packed {
    logic [4:0] count;
    logic       start;
  } cnt_s;

  cnt_s st_reg;
  cnt_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    if (step) begin
      if (st_reg.count == BURST_LAST) begin
        st_next.count = 5'h00;
        st_next.start = 1'b1;
      end else begin
        st_next.count = st_reg.count + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count        = st_reg.count;
  assign period_start = st_reg.start;
endmodule

// >>> cpu_clock_burst_power_control.sv
// Core clock burst power controller with register port and bus handoff
`timescale 1ns/1ps
module cpu_clock_burst_power_control (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      slow_reference_clock,
  input  wire burst_power_pkg::reg_req_s reg_req,
  output logic [7:0]                     reg_rdata,
  input  wire logic                      wakeup_irq,
  input  wire logic                      core_bus_grant,
  input  wire logic                      core_bus_cycle_active,
  input  wire logic                      dma_busy,
  output logic                           core_clk_en,
  output logic                           core_bus_req,
  output logic                           dma_bus_grant,
  output logic                           core_irq_hold
);
  import burst_power_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Slow reference timing

  logic       slow_rise;
  logic [4:0] burst_count;
  logic       period_start;

  // The slow reference runs at all times, so the period never stalls
  slow_edge_detect u_edge (
    .mclk                 (mclk),
    .rst_n                (rst_n),
    .slow_reference_clock (slow_reference_clock),
    .rise                 (slow_rise)
  );

  burst_counter u_count (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .step         (slow_rise),
    .count        (burst_count),
    .period_start (period_start)
  );

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    ctrl_s       ctrl;
    gate_state_e gstate;
    logic        stop_armed;
    logic        doze_hold;
    logic        clk_en;
    logic        bus_req;
    logic        dma_grant;
    logic        irq_hold;
    logic [7:0]  rdata;
  } pc_s;

  pc_s st_reg;
  pc_s st_next;

  logic slot_active;
  logic want_off;

  always_comb begin
    // Enabled compare: width 0 never on, width 1f always on
    slot_active = (st_reg.ctrl.width == WIDTH_FULL) |
                  (burst_count < st_reg.ctrl.width);
    // Disabled means clock on regardless of width
    want_off = st_reg.ctrl.enable &
               (~slot_active | st_reg.doze_hold);
  end

  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;

    //////////////////////////////////////////////////////////////////////
    // Register port; reads answer in the following cycle only
    if (reg_req.wr) begin
      if (reg_req.addr == CTRL_OFFSET) begin
        st_next.ctrl.enable = reg_req.wdata[ENABLE_BIT];
        st_next.ctrl.stop   = reg_req.wdata[STOP_BIT];
        st_next.ctrl.width  = reg_req.wdata[4:0];
        // A stop written while disabled must not linger for a later enable
        st_next.stop_armed = reg_req.wdata[STOP_BIT] &
                             reg_req.wdata[ENABLE_BIT];
        if (!reg_req.wdata[ENABLE_BIT]) begin
          st_next.doze_hold = 1'b0;
        end
      end
    end else if (reg_req.rd) begin
      if (reg_req.addr == CTRL_OFFSET) begin
        st_next.rdata = {st_reg.ctrl.enable, st_reg.ctrl.stop, 1'b0,
                         st_reg.ctrl.width};
      end else if (reg_req.addr == STATUS_OFFSET) begin
        st_next.rdata = {st_reg.clk_en, st_reg.bus_req,
                         st_reg.dma_grant, burst_count};
      end else begin
        st_next.rdata = 8'h00;
      end
    end

    //////////////////////////////////////////////////////////////////////
    // Stop request: armed on write, doze from next slow edge until next period
    if (st_reg.stop_armed && slow_rise && st_next.ctrl.enable) begin
      st_next.stop_armed = 1'b0;
      st_next.doze_hold  = 1'b1;
    end
    if (period_start) begin
      st_next.doze_hold = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////
    // Wakeup interrupt wins over a same-cycle software set of enable;
    // width is left untouched
    if (wakeup_irq) begin
      st_next.ctrl.enable = 1'b0;
      st_next.ctrl.stop   = 1'b0;
      st_next.stop_armed  = 1'b0;
      st_next.doze_hold   = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////
    // Clock gating and bus handoff; DMA side never gated
    st_next.irq_hold = 1'b0;
    case (st_reg.gstate)
      st_run: begin
        st_next.clk_en    = 1'b1;
        st_next.dma_grant = 1'b0;
        // Stop waits for the core's bus cycle in flight to finish
        if (want_off && !wakeup_irq && !core_bus_cycle_active) begin
          st_next.bus_req = 1'b1;
          st_next.gstate  = st_bus_req;
        end
      end
      st_bus_req: begin
        if (wakeup_irq || !want_off) begin
          st_next.bus_req = 1'b0;
          st_next.gstate  = st_run;
        end else if (core_bus_grant) begin
          st_next.clk_en    = 1'b0;
          st_next.dma_grant = 1'b1;
          st_next.gstate    = st_gated;
        end
      end
      st_gated: begin
        // Only an interrupt, a new period or a software control write restarts
        if (wakeup_irq || !want_off) begin
          st_next.clk_en = 1'b1;
          if (dma_busy) begin
            st_next.irq_hold = 1'b1;
            st_next.gstate   = st_dma_wait;
          end else begin
            st_next.dma_grant = 1'b0;
            st_next.bus_req   = 1'b0;
            st_next.gstate    = st_run;
          end
        end
      end
      st_dma_wait: begin
        // Core clock runs but keeps the bus off until DMA is done
        if (dma_busy) begin
          st_next.irq_hold = 1'b1;
        end else begin
          st_next.dma_grant = 1'b0;
          st_next.bus_req   = 1'b0;
          st_next.gstate    = st_run;
        end
      end
      default: begin
        st_next.gstate = st_run;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg             <= '0;
      st_reg.ctrl.enable <= 1'b0;
      st_reg.ctrl.stop   <= 1'b0;
      st_reg.ctrl.width  <= WIDTH_RESET;
      st_reg.gstate      <= st_run;
      st_reg.clk_en      <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // The system master clock itself is never gated here; only the
  // core enable is. Sleep and PLL restart live outside this block,
  // and WAKE_LIMIT_CYC records the bound they must meet.
  assign reg_rdata     = st_reg.rdata;
  assign core_clk_en   = st_reg.clk_en;
  assign core_bus_req  = st_reg.bus_req;
  assign dma_bus_grant = st_reg.dma_grant;
  assign core_irq_hold = st_reg.irq_hold;
endmodule

// >>> cpu_clock_burst_power_control_chk.sv
// Port-level assertions for the core clock burst power controller
`timescale 1ns/1ps
module cpu_clock_burst_power_control_chk
  import burst_power_pkg::*;
(
  input wire logic                      mclk,
  input wire logic                      rst_n,
  input wire logic                      slow_reference_clock,
  input wire burst_power_pkg::reg_req_s reg_req,
  input wire logic [7:0]                reg_rdata,
  input wire logic                      wakeup_irq,
  input wire logic                      core_bus_grant,
  input wire logic                      core_bus_cycle_active,
  input wire logic                      dma_busy,
  input wire logic                      core_clk_en,
  input wire logic                      core_bus_req,
  input wire logic                      dma_bus_grant,
  input wire logic                      core_irq_hold
);
  logic       ever_en;
  logic       stop_seen;
  logic [4:0] width_sh;
  // Shadow of software writes; the stop path is excluded where it differs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ever_en   <= 1'b0;
      stop_seen <= 1'b0;
      width_sh  <= WIDTH_RESET;
    end else if (reg_req.wr && reg_req.addr == CTRL_OFFSET) begin
      ever_en   <= ever_en | reg_req.wdata[ENABLE_BIT];
      stop_seen <= stop_seen | reg_req.wdata[STOP_BIT];
      width_sh  <= reg_req.wdata[4:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_wake;
    wakeup_irq && !core_clk_en;
  endsequence
  sequence s_parked;
    dma_bus_grant && core_bus_req;
  endsequence
  AST_RESET_RUNS: assert property (!ever_en |-> core_clk_en && !core_bus_req)
    else $error("core clock gated before enable");
  AST_FULL_WIDTH: assert property ($rose(core_bus_req) && !stop_seen
    |-> $past(width_sh) != WIDTH_FULL) else $error("bus request at full width");
  AST_HANDOFF: assert property ($fell(core_clk_en)
    |-> $past(core_bus_grant) && dma_bus_grant) else $error("stop without grant");
  AST_PARKED: assert property (!core_clk_en |-> s_parked)
    else $error("core stopped but bus not handed to dma");
  AST_WAKE: assert property (s_wake |=> core_clk_en)
    else $error("wakeup did not restart core clock");
  AST_HOLD_END: assert property (core_irq_hold && !dma_busy
    |=> !core_irq_hold && !dma_bus_grant) else $error("hold not released");
  AST_DMA_FIRST: assert property ($fell(dma_bus_grant)
    |-> !$past(dma_busy) && core_clk_en) else $error("dma grant cut short");
  AST_HOLD_RUNS: assert property (core_irq_hold |-> core_clk_en && dma_bus_grant)
    else $error("hold without running clock and dma grant");
  AST_READ_WINDOW: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule
bind cpu_clock_burst_power_control cpu_clock_burst_power_control_chk i_chk (
  .mclk(mclk), .rst_n(rst_n), .slow_reference_clock(slow_reference_clock),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .wakeup_irq(wakeup_irq),
  .core_bus_grant(core_bus_grant), .dma_busy(dma_busy),
  .core_bus_cycle_active(core_bus_cycle_active), .core_clk_en(core_clk_en),
  .core_bus_req(core_bus_req), .dma_bus_grant(dma_bus_grant),
  .core_irq_hold(core_irq_hold));

// >>> core_bus_model.sv
// Behavioural core bus and display dma model facing the controller
`timescale 1ns/1ps
module core_bus_model (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic core_clk_en,
  input  wire logic core_bus_req,
  input  wire logic dma_bus_grant,
  input  wire logic slow_grant,
  input  wire logic dma_on,
  output logic      core_bus_grant,
  output logic      core_bus_cycle_active,
  output logic      dma_busy
);
  logic [3:0] tick;
  logic [1:0] wait_cnt;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick           <= 4'h0;
      wait_cnt       <= 2'h0;
      core_bus_grant <= 1'b0;
    end else begin
      tick <= tick + 4'h1;
      if (!core_bus_req) begin
        core_bus_grant <= 1'b0;
        wait_cnt       <= slow_grant ? 2'h2 : 2'h0;
      end else if (wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (!core_bus_cycle_active) begin
        core_bus_grant <= 1'b1;
      end
    end
  end
  // Core keeps cycling until it hands over, so a grant never lands mid-cycle
  assign core_bus_cycle_active = core_clk_en && !core_bus_grant && !tick[1];
  // Eight busy cycles in sixteen, so restarts hit both idle and busy dma
  assign dma_busy = dma_bus_grant && dma_on && tick[3];
endmodule

// >>> cpu_clock_burst_power_control_test.sv
// Self-checking bench for the core clock burst power controller
`timescale 1ns/1ps
module cpu_clock_burst_power_control_test;
  import burst_power_pkg::*;
  logic       mclk, rst_n, slow_reference_clock, wakeup_irq;
  reg_req_s   reg_req;
  logic [7:0] reg_rdata, d;
  logic       core_clk_en, core_bus_req, dma_bus_grant, core_irq_hold;
  logic       core_bus_grant, core_bus_cycle_active, dma_busy;
  logic       slow_grant, dma_on;
  logic [3:0] ph;
  int         cnt, model_ctrl, mismatches, cmp_count, w, k, c;
  int         seed = 32'h786d;
  int         wl[5] = '{0, 1, 2, 30, 31};
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Slow reference sped up to 16 mclk periods to keep the run short
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph                   <= 4'hf;
      cnt                  <= 0;
      slow_reference_clock <= 1'b0;
    end else begin
      ph                   <= ph + 4'h1;
      slow_reference_clock <= (ph + 4'h1) < 4'h8;
      if (ph == 4'hf) cnt <= (cnt == 30) ? 0 : cnt + 1;
    end
  end
  cpu_clock_burst_power_control i_dut (.mclk(mclk), .rst_n(rst_n),
    .slow_reference_clock(slow_reference_clock), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .wakeup_irq(wakeup_irq),
    .core_bus_grant(core_bus_grant), .dma_busy(dma_busy),
    .core_bus_cycle_active(core_bus_cycle_active), .core_clk_en(core_clk_en),
    .core_bus_req(core_bus_req), .dma_bus_grant(dma_bus_grant),
    .core_irq_hold(core_irq_hold));
  core_bus_model i_core (.mclk(mclk), .rst_n(rst_n), .core_clk_en(core_clk_en),
    .core_bus_req(core_bus_req), .dma_bus_grant(dma_bus_grant),
    .slow_grant(slow_grant), .dma_on(dma_on), .core_bus_grant(core_bus_grant),
    .core_bus_cycle_active(core_bus_cycle_active), .dma_busy(dma_busy));
  task automatic print_verdict;
    $display("Compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_ph(input logic [3:0] p);
    int i = 0;
    do begin
      @(posedge mclk);
      #1;
      i++;
    end while (i < 40 && ph !== p);
    if (ph !== p) begin
      mismatches++;
      print_verdict();
    end
  endtask
  // Always lets at least one sample point pass, so nothing is read at
  // the edge that launched the last write
  task automatic sync_cnt(input int v);
    int i = 0;
    do begin
      wait_ph(4'hc);
      i++;
    end while (i < 40 && cnt != v);
    if (cnt != v) begin
      mismatches++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    reg_req <= '0;
    if (a == CTRL_OFFSET) model_ctrl = v & 8'hdf;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    reg_req <= '0;
    #1;
    d = reg_rdata;
  endtask
  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    wakeup_irq = 1'b0;
    slow_grant = 1'b0;
    dma_on = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    model_ctrl = 8'h1f;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(CTRL_OFFSET);
    chk("ctrl", d, model_ctrl[7:0]);
    wait_ph(4'h4);
    rd(STATUS_OFFSET);
    chk("status", d, {3'b100, cnt[4:0]});
    wr(4'h9, 8'h80);
    rd(4'h9);
    chk("unmapped", d, 8'h00);
    wl[2] = 2 + ($random(seed) & 15);
    foreach (wl[k]) begin
      w = wl[k];
      slow_grant = k[0];
      dma_on = k[1];
      wr(CTRL_OFFSET, 8'h80 | w[7:0]);
      sync_cnt(0);
      for (c = 0; c < 31; c++) begin
        chk("clk_en", {7'h00, core_clk_en}, {7'h00, cnt < w});
        wait_ph(4'hc);
      end
    end
    wr(CTRL_OFFSET, 8'h00);
    repeat (3) wait_ph(4'hc);
    chk("disabled", {7'h00, core_clk_en}, 8'h01);
    dma_on = 1'b1;
    for (k = 0; k < 6; k++) begin
      w = $random(seed) & 32'h7;
      slow_grant = k[0];
      wr(CTRL_OFFSET, 8'h80 | w[7:0]);
      repeat (40 + ($random(seed) & 127)) @(posedge mclk);
      wakeup_irq <= 1'b1;
      @(posedge mclk);
      wakeup_irq <= 1'b0;
      #1;
      chk("wake", {7'h00, core_clk_en}, 8'h01);
      model_ctrl = w;
      rd(CTRL_OFFSET);
      chk("ctrl", d, model_ctrl[7:0]);
      repeat (20) @(posedge mclk);
    end
    wr(CTRL_OFFSET, 8'h9f);
    sync_cnt(3);
    wait_ph(4'h4);
    wr(CTRL_OFFSET, 8'hdf);
    wait_ph(4'hc);
    for (c = 4; c <= 31; c++) begin
      chk("doze", {7'h00, core_clk_en}, {7'h00, cnt == 4 || cnt == 0});
      wait_ph(4'hc);
    end
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    model_ctrl = 8'h1f;
    rd(CTRL_OFFSET);
    chk("ctrl", d, model_ctrl[7:0]);
    chk("reset clk_en", {7'h00, core_clk_en}, 8'h01);
    print_verdict();
  end
endmodule
